// [verilog/lscd_decoder.sv]
`timescale 1ns/1ps
`include "lscd_defs.svh"
// What this block does
// - Two outputs, each three-level, nine combinations
// - A positive: standby, normal direct, normal reverse
// - A zero boost; A negative only ringing
// - Low two bits zero and ring bit clear selects standby
// - All-zero byte gives power-down denial
// - Standby forces direct polarity, normal battery
// - Standby keeps sensors, limits current 7 mA
// - Standby hook: below 5 on, above 7 off
// - Boost bit picks battery in conversation
// - Polarity bit and limit bits in conversation
// - Polarity change allowed during conversation
// - Metering any conversation, 2 or 5 Vrms
// - Metering pulses ramp up and down
// - Metering allowed with zero line current
// - Ring bit with impedance zero selects ringing
// - Eight clocks shifted, latched on select rise
// - Impedance bit: zero standby/ring, one conversation

module lscd_decoder (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial control pins
  input wire logic serial_select_low,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic serial_write_mode,
  // Line current sense, microamps
  input wire logic [16:0] line_current_ua,
  input wire logic meter_request,
  // Drive to the line circuit
  output lscd_pkg::lscd_drive_t drive,
  output lscd_pkg::lscd_mode_t mode,
  // Line status
  output logic off_hook,
  output logic [15:0] metering_tone,
  output logic metering_active
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic meter_meta;
  logic meter_sync;

  // Two flops before any logic sees a pin
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_meta <= 4'h8; // Idle pin levels, so no false edge follows reset
      pin_sync <= 4'h8;
      meter_meta <= 1'b0;
      meter_sync <= 1'b0;
    end else begin
      pin_meta <= {serial_select_low, serial_clock_in, serial_data_in, serial_write_mode};
      pin_sync <= pin_meta;
      meter_meta <= meter_request;
      meter_sync <= meter_meta;
    end
  end

  // ----------------------------------------
  // Serial receive
  // ----------------------------------------
  lscd_pkg::lscd_cmd_t cmd;
  logic cmd_strobe;

  lscd_serial_rx u_rx (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .select_low_s(pin_sync[3]),
    .serial_clock_s(pin_sync[2]),
    .data_s(pin_sync[1]),
    .write_mode_s(pin_sync[0]),
    .cmd(cmd),
    .cmd_strobe(cmd_strobe)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  lscd_pkg::lscd_mode_t next_mode;
  lscd_pkg::lscd_cmd_t active_cmd;
  lscd_pkg::lscd_cmd_t next_active_cmd;

  // Limit code to current, also used for the drive
  function automatic logic [16:0] limit_of(input logic hi, input logic lo);
    case ({hi, lo})
      2'b00: limit_of = `LSCD_LIM_25_UA;
      2'b01: limit_of = `LSCD_LIM_30_UA;
      2'b10: limit_of = `LSCD_LIM_45_UA;
      default: limit_of = `LSCD_LIM_70_UA;
    endcase
  endfunction

  // Decode a new byte only on its strobe; the mode holds between bytes
  always_comb begin
    next_mode = mode;
    next_active_cmd = active_cmd;
    if (cmd_strobe) begin
      next_active_cmd = cmd;
      if (cmd == lscd_pkg::lscd_cmd_t'(8'h00))
        next_mode = lscd_pkg::LSCD_MODE_POWER_DENIAL;
      else if (cmd.impedance_sel)
        next_mode = lscd_pkg::LSCD_MODE_CONVERSATION;
      else if (cmd.ring_select)
        next_mode = lscd_pkg::LSCD_MODE_RINGING;
      else
        next_mode = lscd_pkg::LSCD_MODE_STANDBY;
      // Polarity may change inside conversation with no detour
    end
  end

  // Mode registers, standby out of reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode <= lscd_pkg::LSCD_MODE_STANDBY;
      active_cmd <= lscd_pkg::lscd_cmd_t'(`LSCD_CMD_RESET);
    end else begin
      mode <= next_mode;
      active_cmd <= next_active_cmd;
    end
  end

  // ----------------------------------------
  // Drive generation
  // ----------------------------------------
  lscd_pkg::lscd_drive_t next_drive;

  // Only the six allowed combinations can be produced
  always_comb begin
    next_drive = '0;
    next_drive.state_ctrl_a = `LSCD_LVL_POS;
    next_drive.state_ctrl_b = `LSCD_LVL_POS;
    next_drive.hook_sense_en = 1'b1;
    next_drive.bias_reduced = 1'b1;
    next_drive.limit_ua = `LSCD_LIM_SBY_UA;
    case (mode)
      lscd_pkg::LSCD_MODE_STANDBY: begin
        next_drive.state_ctrl_a = `LSCD_LVL_POS;
        next_drive.state_ctrl_b = `LSCD_LVL_POS;
        next_drive.reverse = 1'b0;
        next_drive.boosted_battery = 1'b0;
        next_drive.limit_ua = `LSCD_LIM_SBY_UA;
      end
      lscd_pkg::LSCD_MODE_POWER_DENIAL: begin
        next_drive.hook_sense_en = 1'b0;
        next_drive.limit_ua = `LSCD_LIM_PD_UA;
      end
      lscd_pkg::LSCD_MODE_CONVERSATION: begin
        next_drive.bias_reduced = 1'b0;
        next_drive.reverse = active_cmd.polarity_sel;
        next_drive.boosted_battery = active_cmd.boost_sel;
        next_drive.limit_ua = limit_of(active_cmd.limit_sel_hi, active_cmd.limit_sel_lo);
        next_drive.state_ctrl_a = active_cmd.boost_sel ? `LSCD_LVL_ZERO : `LSCD_LVL_POS;
        next_drive.state_ctrl_b = active_cmd.polarity_sel ? `LSCD_LVL_NEG : `LSCD_LVL_ZERO;
      end
      lscd_pkg::LSCD_MODE_RINGING: begin
        next_drive.bias_reduced = 1'b0;
        next_drive.state_ctrl_a = `LSCD_LVL_NEG;
        next_drive.state_ctrl_b = `LSCD_LVL_ZERO;
      end
      default: begin
        next_drive.state_ctrl_a = `LSCD_LVL_POS;
      end
    endcase
  end

  // Drive register, standby combination from reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      drive.state_ctrl_a <= `LSCD_LVL_POS;
      drive.state_ctrl_b <= `LSCD_LVL_POS;
      drive.reverse <= 1'b0;
      drive.boosted_battery <= 1'b0;
      drive.bias_reduced <= 1'b1;
      drive.hook_sense_en <= 1'b1;
      drive.limit_ua <= `LSCD_LIM_SBY_UA;
    end else begin
      drive <= next_drive;
    end
  end

  // ----------------------------------------
  // Hook detection
  // ----------------------------------------
  logic next_off_hook;

  // Hysteresis between thresholds avoids chatter near the limit
  always_comb begin
    next_off_hook = off_hook;
    if (!drive.hook_sense_en)
      next_off_hook = 1'b0;
    else if (line_current_ua > {1'b0, `LSCD_OFFHOOK_UA})
      next_off_hook = 1'b1;
    else if (line_current_ua < {1'b0, `LSCD_ONHOOK_UA})
      next_off_hook = 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      off_hook <= 1'b0;
    end else begin
      off_hook <= next_off_hook;
    end
  end

  // ----------------------------------------
  // Metering
  // ----------------------------------------
  logic meter_en;

  // No current check here: on-hook metering is legal
  assign meter_en = meter_sync && mode == lscd_pkg::LSCD_MODE_CONVERSATION;

  lscd_meter_ramp u_ramp (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .enable(meter_en),
    .level_hi(active_cmd.metering_level),
    .level_mv(metering_tone),
    .active(metering_active)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Byte latched for conversation
  sequence s_strobe_conv;
    cmd_strobe && cmd.impedance_sel && cmd != lscd_pkg::lscd_cmd_t'(8'h00);
  endsequence

  // All-zero byte latched
  sequence s_strobe_zero;
    cmd_strobe && cmd == lscd_pkg::lscd_cmd_t'(8'h00);
  endsequence

  // Stand-by byte latched; a set ring bit takes precedence and is checked apart
  sequence s_strobe_sby;
    cmd_strobe && cmd[1:0] == 2'b00 && !cmd.ring_select
      && cmd != lscd_pkg::lscd_cmd_t'(8'h00);
  endsequence

  // Ringing byte latched
  sequence s_strobe_ring;
    cmd_strobe && !cmd.impedance_sel && cmd.ring_select;
  endsequence

  // Only the six decodable level pairs may ever reach the line circuit
  a_allowed_combos: assert property (@(posedge mclk) disable iff (sys_rst)
    (drive.state_ctrl_a == `LSCD_LVL_POS && drive.state_ctrl_b != 2'h3) ||
    (drive.state_ctrl_a == `LSCD_LVL_ZERO && drive.state_ctrl_b != `LSCD_LVL_POS
      && drive.state_ctrl_b != 2'h3) ||
    (drive.state_ctrl_a == `LSCD_LVL_NEG && drive.state_ctrl_b == `LSCD_LVL_ZERO))
    else $error("Illegal state control combination");
  // Mode settles one cycle after the strobe, the drive register one more
  a_conv_drive: assert property (@(posedge mclk) disable iff (sys_rst)
    s_strobe_conv ##2 1'b1 |-> drive.state_ctrl_b ==
      ($past(cmd.polarity_sel, 2) ? `LSCD_LVL_NEG : `LSCD_LVL_ZERO))
    else $error("Conversation polarity wrong");
  // Battery choice shows on both the level code and the boost flag
  a_conv_battery: assert property (@(posedge mclk) disable iff (sys_rst)
    s_strobe_conv ##2 1'b1 |-> drive.boosted_battery == $past(cmd.boost_sel, 2) &&
      drive.state_ctrl_a == ($past(cmd.boost_sel, 2) ? `LSCD_LVL_ZERO : `LSCD_LVL_POS))
    else $error("Conversation battery wrong");
  // A settled stand-by never shows reverse polarity or boost
  a_sby_direct: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == lscd_pkg::LSCD_MODE_STANDBY && $stable(mode)
      |=> !drive.reverse && !drive.boosted_battery)
    else $error("Standby not direct normal");
  // Stand-by is left only by a new byte, whatever the hook state
  a_sby_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == lscd_pkg::LSCD_MODE_STANDBY && !cmd_strobe
      |=> mode == lscd_pkg::LSCD_MODE_STANDBY)
    else $error("Standby left without a command");
  a_pd_limit: assert property (@(posedge mclk) disable iff (sys_rst)
    s_strobe_zero |=> ##1 drive.limit_ua == `LSCD_LIM_PD_UA && !drive.hook_sense_en)
    else $error("Power-down denial not applied");
  // With sensing off the hook flag clears one cycle behind the drive
  a_pd_blind: assert property (@(posedge mclk) disable iff (sys_rst)
    s_strobe_zero ##3 1'b1 |-> !off_hook && drive.bias_reduced)
    else $error("Power-down denial still senses hook");
  a_ring_sel: assert property (@(posedge mclk) disable iff (sys_rst)
    s_strobe_ring |=> mode == lscd_pkg::LSCD_MODE_RINGING)
    else $error("Ringing not selected");
  // Ringing is the one legal pair with the first output negative
  a_ring_drive: assert property (@(posedge mclk) disable iff (sys_rst)
    s_strobe_ring ##2 1'b1 |-> drive.state_ctrl_a == `LSCD_LVL_NEG
      && drive.state_ctrl_b == `LSCD_LVL_ZERO)
    else $error("Ringing drive wrong");
  a_sby_limit: assert property (@(posedge mclk) disable iff (sys_rst)
    s_strobe_sby |=> ##1 drive.limit_ua == `LSCD_LIM_SBY_UA
      && drive.state_ctrl_a == `LSCD_LVL_POS && drive.state_ctrl_b == `LSCD_LVL_POS)
    else $error("Standby not entered");
  a_hook_high: assert property (@(posedge mclk) disable iff (sys_rst)
    drive.hook_sense_en && line_current_ua > {1'b0, `LSCD_OFFHOOK_UA} |=> off_hook)
    else $error("Off-hook missed");
  // Metering stays silent outside conversation once any tail has ramped away
  a_meter_conv_only: assert property (@(posedge mclk) disable iff (sys_rst)
    mode != lscd_pkg::LSCD_MODE_CONVERSATION && metering_tone == 16'h0000
      |=> metering_tone == 16'h0000)
    else $error("Metering outside conversation");

endmodule // lscd_decoder

// [verilog/lscd_defs.svh]
`ifndef LSCD_DEFS_SVH
`define LSCD_DEFS_SVH

// ----------------------------------------
// Command byte field positions
// ----------------------------------------
`define LSCD_BIT_IMPEDANCE 0
`define LSCD_BIT_TIMING 1
`define LSCD_BIT_RING 2
`define LSCD_BIT_METER_LVL 3
`define LSCD_BIT_POLARITY 4
`define LSCD_BIT_BOOST 5
`define LSCD_BIT_LIMIT_LO 6
`define LSCD_BIT_LIMIT_HI 7
`define LSCD_CMD_BITS 8

// ----------------------------------------
// Reset values and level codes
// ----------------------------------------
`define LSCD_CMD_RESET 8'h00
`define LSCD_LVL_NEG 2'h2
`define LSCD_LVL_ZERO 2'h0
`define LSCD_LVL_POS 2'h1

// ----------------------------------------
// Current thresholds and limits, microamps
// ----------------------------------------
`define LSCD_ONHOOK_UA 16'h1388
`define LSCD_OFFHOOK_UA 16'h1b58
`define LSCD_LIM_SBY_UA 17'h01b58
`define LSCD_LIM_PD_UA 17'h000fa
`define LSCD_LIM_25_UA 17'h061a8
`define LSCD_LIM_30_UA 17'h07530
`define LSCD_LIM_45_UA 17'h0afc8
`define LSCD_LIM_70_UA 17'h11170

// ----------------------------------------
// Metering levels, millivolts rms
// ----------------------------------------
`define LSCD_METER_LO_MV 16'h07d0
`define LSCD_METER_HI_MV 16'h1388

// ----------------------------------------
// Timing
// ----------------------------------------
`define LSCD_CLK_HZ 10000000
`define LSCD_RAMP_US 1000
`define LSCD_RAMP_CYC ((`LSCD_RAMP_US * (`LSCD_CLK_HZ / 1000000)))
`define LSCD_RAMP_STEP 16'h0001

`endif

// [verilog/lscd_pkg.sv]
package lscd_pkg;

  // Three-level line state control drive
  typedef enum logic [1:0] {
    LSCD_LVL_ZERO_E = 2'h0,
    LSCD_LVL_POS_E = 2'h1,
    LSCD_LVL_NEG_E = 2'h2
  } lscd_level_t;

  // Decoded working mode
  typedef enum logic [2:0] {
    LSCD_MODE_STANDBY,
    LSCD_MODE_POWER_DENIAL,
    LSCD_MODE_CONVERSATION,
    LSCD_MODE_RINGING
  } lscd_mode_t;

  // Fields of a latched command byte
  typedef struct packed {
    logic limit_sel_hi;
    logic limit_sel_lo;
    logic boost_sel;
    logic polarity_sel;
    logic metering_level;
    logic ring_select;
    logic timing_enable;
    logic impedance_sel;
  } lscd_cmd_t;

  // Drive to the line circuit
  typedef struct packed {
    logic [1:0] state_ctrl_a;
    logic [1:0] state_ctrl_b;
    logic reverse;
    logic boosted_battery;
    logic bias_reduced;
    logic hook_sense_en;
    logic [16:0] limit_ua;
  } lscd_drive_t;

endpackage

// [verilog/lscd_serial_rx.sv]
`timescale 1ns/1ps
`include "lscd_defs.svh"

module lscd_serial_rx (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial pins, already synchronised
  input wire logic select_low_s,
  input wire logic serial_clock_s,
  input wire logic data_s,
  input wire logic write_mode_s,
  // Latched byte
  output lscd_pkg::lscd_cmd_t cmd,
  output logic cmd_strobe
);

  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [3:0] count;
  logic [3:0] next_count;
  logic clk_d;
  logic sel_d;
  lscd_pkg::lscd_cmd_t next_cmd;
  logic next_strobe;
  logic rise_clk;
  logic rise_sel;

  assign rise_clk = serial_clock_s & ~clk_d;
  assign rise_sel = select_low_s & ~sel_d;

  // Shift on rising clock while selected, latch on select release
  always_comb begin
    next_shift = shift;
    next_count = count;
    next_cmd = cmd;
    next_strobe = 1'b0;
    if (!select_low_s && !write_mode_s && rise_clk) begin
      next_shift = {shift[6:0], data_s};
      if (count != 4'h8)
        next_count = count + 4'h1;
    end
    if (rise_sel) begin
      // A short frame is dropped rather than executed half-loaded
      if (count == 4'h8 && !write_mode_s) begin
        next_cmd = lscd_pkg::lscd_cmd_t'(shift);
        next_strobe = 1'b1;
      end
      next_count = 4'h0;
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shift <= 8'h00;
      count <= 4'h0;
      cmd <= lscd_pkg::lscd_cmd_t'(`LSCD_CMD_RESET);
      cmd_strobe <= 1'b0;
      clk_d <= 1'b0;
      sel_d <= 1'b1;
    end else begin
      shift <= next_shift;
      count <= next_count;
      cmd <= next_cmd;
      cmd_strobe <= next_strobe;
      clk_d <= serial_clock_s;
      sel_d <= select_low_s;
    end
  end

  a_latch_full_byte: assert property (@(posedge mclk) disable iff (sys_rst)
    cmd_strobe |-> $past(count) == 4'h8) else $error("Byte latched short");

endmodule // lscd_serial_rx

// [verilog/lscd_meter_ramp.sv]
`timescale 1ns/1ps
`include "lscd_defs.svh"

module lscd_meter_ramp (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Request
  input wire logic enable,
  input wire logic level_hi,
  // Shaped envelope in millivolts rms
  output logic [15:0] level_mv,
  output logic active
);

  logic [15:0] target;
  logic [15:0] next_level;

  // Step toward target each cycle so edges never click
  always_comb begin
    target = enable ? (level_hi ? `LSCD_METER_HI_MV : `LSCD_METER_LO_MV) : 16'h0000;
    next_level = level_mv;
    if (level_mv < target)
      next_level = level_mv + `LSCD_RAMP_STEP;
    else if (level_mv > target)
      next_level = level_mv - `LSCD_RAMP_STEP;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      level_mv <= 16'h0000;
    end else begin
      level_mv <= next_level;
    end
  end

  assign active = level_mv != 16'h0000;

  a_ramp_no_jump: assert property (@(posedge mclk) disable iff (sys_rst)
    ($past(level_mv) - level_mv <= 16'h0001) || (level_mv - $past(level_mv) <= 16'h0001))
    else $error("Metering level jumped");

endmodule // lscd_meter_ramp

// [verif/lscd_line_model.sv]
`timescale 1ns/1ps

module lscd_line_model #(
  parameter logic [16:0] SLACK_UA = 17'h001f4
) (
  // Drive from the decoder
  input wire lscd_pkg::lscd_drive_t drive,
  // Handset load and sensed current
  input wire logic [16:0] demand_ua,
  output logic [16:0] line_current_ua,
  output logic illegal
);
  logic [16:0] ceiling;

  // ----------------------------------------
  // Line current
  // ----------------------------------------
  // A real limiter overshoots a little, so the clip sits just above the limit
  always_comb begin
    ceiling = drive.limit_ua + SLACK_UA;
    line_current_ua = (demand_ua > ceiling) ? ceiling : demand_ua;
  end

  // ----------------------------------------
  // State decoder of the line circuit
  // ----------------------------------------
  // Combinations the line circuit cannot decode
  always_comb begin
    illegal = 1'b0;
    if (drive.state_ctrl_a == 2'h3 || drive.state_ctrl_b == 2'h3) illegal = 1'b1;
    if (drive.state_ctrl_a == 2'h0 && drive.state_ctrl_b == 2'h1) illegal = 1'b1;
    if (drive.state_ctrl_a == 2'h2 && drive.state_ctrl_b != 2'h0) illegal = 1'b1;
  end
endmodule // lscd_line_model

// [verif/tb_line_state_command_decoder.sv]
`timescale 1ns/1ps

module tb_line_state_command_decoder;
  logic mclk;
  logic sys_rst;
  logic serial_select_low;
  logic serial_clock_in;
  logic serial_data_in;
  logic serial_write_mode;
  logic meter_request;
  logic [16:0] demand_ua;
  logic [16:0] line_current_ua;
  logic illegal;
  lscd_pkg::lscd_drive_t drive;
  lscd_pkg::lscd_mode_t mode;
  logic off_hook;
  logic [15:0] metering_tone;
  logic metering_active;
  logic arm;
  logic left_conv;
  int n_fail;
  int check_count;

  // ----------------------------------------
  // Clock, instances, monitors
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  lscd_decoder u_lscd_decoder (
    .mclk(mclk), .sys_rst(sys_rst), .serial_select_low(serial_select_low),
    .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
    .serial_write_mode(serial_write_mode), .line_current_ua(line_current_ua),
    .meter_request(meter_request), .drive(drive), .mode(mode), .off_hook(off_hook),
    .metering_tone(metering_tone), .metering_active(metering_active)
  );

  lscd_line_model u_lscd_line_model (
    .drive(drive), .demand_ua(demand_ua), .line_current_ua(line_current_ua), .illegal(illegal)
  );

  // Catches a momentary drop out of conversation during a live reversal
  always @(posedge mclk) begin
    if (!arm) left_conv <= 1'b0;
    else if (mode !== lscd_pkg::LSCD_MODE_CONVERSATION) left_conv <= 1'b1;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Pins hold each level three cycles so the synchronisers see every edge
  task automatic send(input logic [7:0] b, input int nclk, input logic wm);
    serial_write_mode = wm;
    serial_select_low = 1'b0;
    tick(3);
    for (int i = 0; i < nclk; i++) begin
      serial_data_in = b[7 - i];
      serial_clock_in = 1'b1;
      tick(3);
      serial_clock_in = 1'b0;
      tick(3);
    end
    serial_select_low = 1'b1;
    tick(3);
    serial_write_mode = 1'b0;
    tick(10);
  endtask

  // Expected drive worked out from the command byte alone
  task automatic expect_cmd(input logic [7:0] b);
    logic [1:0] ea;
    logic [1:0] eb;
    logic [16:0] el;
    lscd_pkg::lscd_mode_t em;
    ea = 2'h1;
    eb = 2'h1;
    el = 17'h01b58;
    em = lscd_pkg::LSCD_MODE_STANDBY;
    if (b == 8'h00) begin
      el = 17'h000fa;
      em = lscd_pkg::LSCD_MODE_POWER_DENIAL;
    end else if (b[0]) begin
      ea = b[5] ? 2'h0 : 2'h1;
      eb = b[4] ? 2'h2 : 2'h0;
      el = (b[7:6] == 2'h0) ? 17'h061a8 : (b[7:6] == 2'h1) ? 17'h07530 :
           (b[7:6] == 2'h2) ? 17'h0afc8 : 17'h11170;
      em = lscd_pkg::LSCD_MODE_CONVERSATION;
    end else if (b[2]) begin
      ea = 2'h2;
      eb = 2'h0;
      em = lscd_pkg::LSCD_MODE_RINGING;
    end
    chk({30'h0, drive.state_ctrl_a}, {30'h0, ea});
    chk({30'h0, drive.state_ctrl_b}, {30'h0, eb});
    chk({31'h0, drive.reverse}, {31'h0, b[0] & b[4]});
    chk({31'h0, drive.boosted_battery}, {31'h0, b[0] & b[5]});
    chk({29'h0, mode}, {29'h0, em});
    chk({31'h0, illegal}, 32'h0);
    if (em != lscd_pkg::LSCD_MODE_RINGING) chk({15'h0, drive.limit_ua}, {15'h0, el});
    chk({31'h0, drive.hook_sense_en}, {31'h0, b != 8'h00});
    chk({31'h0, drive.bias_reduced}, {31'h0, !b[0] && !b[2]});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Every command class, each limit code, boost and polarity in stand-by too
  task automatic t_decode;
    logic [7:0] tbl [13] = '{8'h01, 8'h41, 8'h81, 8'hc1, 8'h11, 8'h21, 8'h31, 8'h35,
                             8'he4, 8'hf0, 8'h08, 8'hf8, 8'h00};
    foreach (tbl[i]) begin
      send(tbl[i], 8, 1'b0);
      expect_cmd(tbl[i]);
    end
  endtask

  // Reversal applied while already in conversation, then short and read frames
  task automatic t_reverse_refuse;
    send(8'h21, 8, 1'b0);
    arm = 1'b1;
    send(8'h31, 8, 1'b0);
    arm = 1'b0;
    chk({31'h0, left_conv}, 32'h0);
    expect_cmd(8'h31);
    send(8'h01, 7, 1'b0);
    expect_cmd(8'h31);
    send(8'h01, 8, 1'b1);
    expect_cmd(8'h31);
  endtask

  // Hook hysteresis in stand-by, then blind sensing in power-down denial
  task automatic t_hook;
    send(8'h08, 8, 1'b0);
    demand_ua = 17'h04e20;
    tick(30);
    chk({31'h0, off_hook}, 32'h1);
    demand_ua = 17'h01770;
    tick(30);
    chk({31'h0, off_hook}, 32'h1);
    demand_ua = 17'h00bb8;
    tick(30);
    chk({31'h0, off_hook}, 32'h0);
    demand_ua = 17'h01770;
    tick(30);
    chk({31'h0, off_hook}, 32'h0);
    chk({29'h0, mode}, {29'h0, lscd_pkg::LSCD_MODE_STANDBY});
    send(8'h00, 8, 1'b0);
    demand_ua = 17'h04e20;
    tick(30);
    chk({31'h0, off_hook}, 32'h0);
    demand_ua = 17'h00000;
  endtask

  task automatic wait_tone(input logic [15:0] v);
    int k;
    k = 0;
    while (metering_tone !== v && k < 8000) begin
      tick(1);
      k++;
    end
    chk({16'h0, metering_tone}, {16'h0, v});
  endtask

  // Metering on an idle line, both levels, ramped in and out
  task automatic t_meter;
    send(8'h01, 8, 1'b0);
    meter_request = 1'b1;
    tick(100);
    chk({31'h0, metering_tone > 16'h0000 && metering_tone < 16'h07d0}, 32'h1);
    wait_tone(16'h07d0);
    chk({31'h0, metering_active}, 32'h1);
    send(8'h19, 8, 1'b0);
    wait_tone(16'h1388);
    meter_request = 1'b0;
    tick(100);
    chk({31'h0, metering_tone > 16'h07d0 && metering_tone < 16'h1388}, 32'h1);
    wait_tone(16'h0000);
    chk({31'h0, metering_active}, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    n_fail = 0;
    check_count = 0;
    sys_rst = 1'b1;
    serial_select_low = 1'b1;
    serial_clock_in = 1'b0;
    serial_data_in = 1'b0;
    serial_write_mode = 1'b0;
    meter_request = 1'b0;
    demand_ua = 17'h00000;
    arm = 1'b0;
    tick(10);
    sys_rst = 1'b0;
    tick(2);
    expect_cmd(8'h08);
    t_decode;
    t_reverse_refuse;
    t_hook;
    t_meter;
    wrap_up;
  end

  // Whole run needs about 12000 cycles; 60000 leaves ample margin
  initial begin
    #6000000;
    n_fail++;
    wrap_up;
  end
endmodule // tb_line_state_command_decoder
